// ===== hdl/obt_pkg.sv
/*
  package for the observe-only test access port: tap states, instruction
  codes, chain lengths and synchroniser depth.
  assumes one system clock much faster than the test clock.
*/
package obt_pkg;
  // tap controller states, one-hot
  typedef enum logic [15:0] {
    ST_RESET = 16'h0001,
    ST_IDLE = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SHIFT_DR = 16'h0010,
    ST_EXIT1_DR = 16'h0020,
    ST_PAUSE_DR = 16'h0040,
    ST_EXIT2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SHIFT_IR = 16'h0800,
    ST_EXIT1_IR = 16'h1000,
    ST_PAUSE_IR = 16'h2000,
    ST_EXIT2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } obt_state_e;

  localparam int IR_LEN = 4;
  localparam int ID_LEN = 32;
  localparam int BSR_LEN_DEF = 8;
  localparam int SYNC_STAGES = 2;
  // instruction codes; all-ones is bypass per custom
  localparam logic [IR_LEN-1:0] IR_EXTEST = 4'h0;
  localparam logic [IR_LEN-1:0] IR_SAMPLE = 4'h1;
  localparam logic [IR_LEN-1:0] IR_IDCODE = 4'h2;
  localparam logic [IR_LEN-1:0] IR_BYPASS = 4'hf;
  // value after reset and the fixed capture pattern of the ir
  localparam logic [IR_LEN-1:0] IR_RESET_VAL = IR_IDCODE;
  localparam logic [IR_LEN-1:0] IR_CAPTURE_VAL = 4'h1;
  // identification word; value arbitrary, bit 0 set as custom requires
  localparam logic [ID_LEN-1:0] ID_VALUE_DEF = 32'h1234_5679;
endpackage : obt_pkg

// ===== hdl/obt_tap.sv
/*
  observe-only boundary scan test access port: tap controller, instruction
  register, identification, bypass and capture-only boundary chain.
  assumes clk oversamples tck by at least eight; tck, tms, tdi and the
  observed pins come from outside the clk domain.
*/
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - exactly four test signals: clock, mode select, data in, data out
// - each rising test clock moves the standard tap machine by mode select
// - data shifts in on data in and out on data out in shift states
// - no test reset pin nor returned clock; reset by mode-select sequencing
// - boundary cells only capture pins, never drive them, any instruction
// - a 32-bit identification word is readable through the port
// - boundary chain observes set pins in fixed order, data in to out
// - data out changes after the falling test clock edge
module obt_tap
  import obt_pkg::*;
#(
  parameter int BSR_LEN = obt_pkg::BSR_LEN_DEF,
  parameter logic [31:0] ID_VALUE = obt_pkg::ID_VALUE_DEF
)
(
  // system
  input wire logic clk,
  input wire logic sys_rst,
  // test port pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo_out,
  output logic tdo_oe,
  // observed device pins, chain order index 0 nearest data out
  input wire logic [BSR_LEN-1:0] obs_pins,
  // status
  output logic [15:0] tap_state
);
  import obt_pkg::*;

  // two-flop synchronisers; first stage feeds only the second
  logic [SYNC_STAGES-1:0] tck_s;
  logic [SYNC_STAGES-1:0] tms_s;
  logic [SYNC_STAGES-1:0] tdi_s;
  logic [BSR_LEN-1:0] pin_s0;
  logic [BSR_LEN-1:0] pin_s1;
  logic tck_d;
  logic tck_rise;
  logic tck_fall;

  always_ff @(posedge clk)
  begin
    tck_s <= {tck_s[0], tck};
    tms_s <= {tms_s[0], tms};
    tdi_s <= {tdi_s[0], tdi};
    pin_s0 <= obs_pins;
    pin_s1 <= pin_s0;
  end

  // no reset: tck_d tracks the pin through reset, so a release while
  // tck idles high never shows a false rising edge
  always_ff @(posedge clk)
  begin
    tck_d <= tck_s[1];
  end

  assign tck_rise = tck_s[1] & ~tck_d;
  assign tck_fall = ~tck_s[1] & tck_d;

  // tap controller
  obt_state_e state;
  obt_state_e next_state;

  function automatic obt_state_e tap_next(input obt_state_e s,
                                          input logic m);
    case (s)
      ST_RESET: tap_next = m ? ST_RESET : ST_IDLE;
      ST_IDLE: tap_next = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: tap_next = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: tap_next = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: tap_next = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: tap_next = m ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: tap_next = m ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: tap_next = m ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: tap_next = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: tap_next = m ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: tap_next = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: tap_next = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: tap_next = m ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: tap_next = m ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: tap_next = m ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR: tap_next = m ? ST_SEL_DR : ST_IDLE;
      default: tap_next = ST_RESET;
    endcase
  endfunction : tap_next

  always_comb
  begin
    next_state = tap_next(state, tms_s[1]);
  end

  // no test reset pin: five tms-high clocks reach reset from anywhere
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      state <= ST_RESET;
    else if (tck_rise)
      state <= next_state;
  end

  assign tap_state = state;

  // instruction register
  logic [IR_LEN-1:0] ir_shift;
  logic [IR_LEN-1:0] ir;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ir_shift <= '0;
    else if (tck_rise)
    begin
      case (state)
        ST_CAP_IR: ir_shift <= IR_CAPTURE_VAL;
        ST_SHIFT_IR: ir_shift <= {tdi_s[1], ir_shift[IR_LEN-1:1]};
        default: ir_shift <= ir_shift;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ir <= IR_RESET_VAL;
    else if (tck_rise && state == ST_RESET)
      ir <= IR_RESET_VAL;
    else if (tck_rise && state == ST_UPD_IR)
      ir <= ir_shift;
  end

  // data registers
  logic [ID_LEN-1:0] id_shift;
  logic [BSR_LEN-1:0] bsr;
  logic bypass;
  logic sel_bsr;
  logic sel_id;

  // extest kept observe-only: it selects the chain but never drives pins
  assign sel_bsr = (ir == IR_SAMPLE) || (ir == IR_EXTEST);
  assign sel_id = (ir == IR_IDCODE);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      id_shift <= '0;
    else if (tck_rise && sel_id)
    begin
      if (state == ST_CAP_DR)
        id_shift <= ID_VALUE;
      else if (state == ST_SHIFT_DR)
        id_shift <= {tdi_s[1], id_shift[ID_LEN-1:1]}; // lsb first
    end
  end

  // capture only; there is no update latch, so no path to any pin
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      bsr <= '0;
    else if (tck_rise && sel_bsr)
    begin
      if (state == ST_CAP_DR)
        bsr <= pin_s1;
      else if (state == ST_SHIFT_DR)
        bsr <= {tdi_s[1], bsr[BSR_LEN-1:1]};
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      bypass <= 1'b0;
    else if (tck_rise && !sel_id && !sel_bsr)
    begin
      if (state == ST_CAP_DR)
        bypass <= 1'b0;
      else if (state == ST_SHIFT_DR)
        bypass <= tdi_s[1];
    end
  end

  // output stage, updated on the falling test clock
  logic shifting;
  logic next_tdo;

  assign shifting = (state == ST_SHIFT_DR) || (state == ST_SHIFT_IR);

  always_comb
  begin
    if (state == ST_SHIFT_IR)
      next_tdo = ir_shift[0];
    else if (sel_id)
      next_tdo = id_shift[0];
    else if (sel_bsr)
      next_tdo = bsr[0];
    else
      next_tdo = bypass;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tdo_out <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo_out <= shifting ? next_tdo : 1'b0;
      tdo_oe <= shifting;
    end
  end
endmodule : obt_tap
`default_nettype wire

// ===== dv/obt_tap_monitor.sv
/* checker of the test port timing; bound into obt_tap, sees its ports. */
`timescale 1ns/10ps
`default_nettype none
module obt_tap_monitor
  import obt_pkg::*;
(
  // watched ports
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdo_out,
  input wire logic tdo_oe,
  input wire logic [15:0] tap_state
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_reset_state: assert property (disable iff (1'b0)
    sys_rst |=> tap_state == ST_RESET) else $error("no reset state");
  a_tdo_quiet: assert property (!tdo_oe |-> !tdo_out)
    else $error("tdo set while off");
  a_state_onehot: assert property ($onehot(tap_state))
    else $error("state not one-hot");
  a_state_on_rise: assert property ($changed(tap_state) |-> $past(tck))
    else $error("state moved off rise");
  a_idle_exit: assert property ($changed(tap_state) &&
    $past(tap_state) == ST_IDLE |-> tap_state == ST_SEL_DR && tms)
    else $error("bad idle exit");
  a_shift_exit: assert property ($changed(tap_state) &&
    $past(tap_state) == ST_SHIFT_DR |-> tap_state == ST_EXIT1_DR && tms)
    else $error("bad shift exit");
  a_tdo_on_fall: assert property ($changed(tdo_out) |-> !$past(tck))
    else $error("tdo moved while tck high");
  a_oe_on_fall: assert property ($changed(tdo_oe) |-> !$past(tck))
    else $error("enable moved while tck high");
endmodule : obt_tap_monitor
bind obt_tap obt_tap_monitor i_mon(.clk(clk), .sys_rst(sys_rst), .tck(tck),
  .tms(tms), .tdo_out(tdo_out), .tdo_oe(tdo_oe), .tap_state(tap_state));
`default_nettype wire

// ===== dv/obt_host.sv
/* test host model; makes tck, tms, tdi from clk, 8 clk per tck. */
`timescale 1ns/10ps
`default_nettype none
module obt_host
(
  // system
  input wire logic clk,
  // test port
  output logic tck,
  output logic tms,
  output logic tdi
);
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // tms and tdi move at the fall, so setup before the rise is long
  task step(input logic m, input logic d);
    @(posedge clk);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge clk);
    tck <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : step
  task reset_tap();
    repeat (6) step(1'b1, ~tdi);
    step(1'b0, ~tdi);
  endtask : reset_tap
  // idle tdi toggles so a stale value is never mistaken for data
  task scan(input logic ir, input logic [31:0] v, input int n);
    step(1'b1, ~tdi);
    if (ir) step(1'b1, ~tdi);
    step(1'b0, ~tdi);
    step(1'b0, ~tdi);
    for (int i = 0; i < n; i++) step(i == n - 1, v[i]);
    step(1'b1, ~tdi);
    step(1'b0, ~tdi);
  endtask : scan
endmodule : obt_host
`default_nettype wire

// ===== dv/observe_only_boundary_scan_tap_test.sv
/* bench: host model drives the port, a watcher compares data out. */
`timescale 1ns/10ps
`default_nettype none
module observe_only_boundary_scan_tap_test;
  import obt_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] obs_pins = 8'h00;
  logic tck, tms, tdi, tdo_out, tdo_oe;
  logic [15:0] tap_state;
  logic exp_q[$];
  logic [31:0] rnd = 32'h6d13;
  logic [3:0] codes [4] = '{IR_SAMPLE, IR_EXTEST, IR_BYPASS, 4'h5};
  int err_total = 0;
  int comparisons = 0;
  always #50 clk = ~clk;
  obt_host i_host(.clk(clk), .tck(tck), .tms(tms), .tdi(tdi));
  obt_tap i_dut(.clk(clk), .sys_rst(sys_rst), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo_out(tdo_out), .tdo_oe(tdo_oe), .obs_pins(obs_pins),
    .tap_state(tap_state));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task check(input logic [31:0] e, input logic [31:0] s, input string w);
    comparisons++;
    if (s !== e)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", w, e, s);
    end
  endtask : check
  task finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  task expect_bits(input logic [31:0] v, input int n);
    for (int i = 0; i < n; i++) exp_q.push_back(v[i]);
  endtask : expect_bits
  // tdo settles 3 clk after a fall and stands until the next fall
  always @(negedge tck)
    if (tdo_oe === 1'b1)
      check(exp_q.size() ? exp_q.pop_front() : 1'bx, tdo_out, "tdo");
  initial
  begin
    #1000000;
    err_total++;
    finish_test();
  end
  initial
  begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    check(ST_RESET, tap_state, "state");
    i_host.reset_tap();
    repeat (2) @(posedge clk);
    check(ST_IDLE, tap_state, "state");
    expect_bits(ID_VALUE_DEF, ID_LEN);
    i_host.scan(1'b0, 32'h0, ID_LEN);
    foreach (codes[k])
    begin
      int n;
      n = (codes[k] inside {IR_SAMPLE, IR_EXTEST}) ? BSR_LEN_DEF : 4;
      rnd = lfsr(rnd);
      obs_pins <= rnd[7:0];
      expect_bits({28'h0, IR_CAPTURE_VAL}, IR_LEN);
      i_host.scan(1'b1, {28'h0, codes[k]}, IR_LEN);
      if (n == 4)
        expect_bits({rnd[2:0], 1'b0}, 4);
      else
        expect_bits(rnd[7:0], n);
      i_host.scan(1'b0, rnd, n);
    end
    // tms sequencing alone must bring back the id instruction
    i_host.reset_tap();
    expect_bits(ID_VALUE_DEF, ID_LEN);
    i_host.scan(1'b0, rnd, ID_LEN);
    // mid-run reset with tck idle high must not fake a tck edge
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    check(ST_RESET, tap_state, "state");
    i_host.reset_tap();
    expect_bits(ID_VALUE_DEF, ID_LEN);
    i_host.scan(1'b0, ~rnd, ID_LEN);
    check(0, exp_q.size(), "queue");
    finish_test();
  end
endmodule : observe_only_boundary_scan_tap_test
`default_nettype wire
